// File: verilog/idf_forward.sv
// ISA/DMA memory cycle forwarding decode with APB registers
`timescale 1ns/1ps
`default_nettype none
module idf_forward
	import idf_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [IDF_PAW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cyc_valid,
	input wire logic [IDF_CAW-1:0] cyc_addr,
	input wire logic cyc_write,
	output logic route_valid,
	output logic route_to_pci,
	output logic [2:0] route_region,
	output logic bios_chip_select_n
);
	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [7:0] isa_dma_forwarding_control;
	logic [7:0] bios_chip_select_control;
	logic [7:0] memory_hole_control;
	logic [IDF_CNTW-1:0] pci_count;
	logic [IDF_CNTW-1:0] isa_count;
	logic last_to_pci;
	logic last_write;
	idf_region_t last_region;
	logic [3:0] last_mbyte;
	logic seen;

	// ----------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------
	logic wr_en;
	logic lane0;
	logic sel_fwd;
	logic sel_bcs;
	logic sel_hole;
	logic sel_stat;
	logic sel_fcnt;
	logic sel_icnt;
	logic mapped;
	logic wr_fwd;
	logic wr_bcs;
	logic wr_hole;
	logic wr_fcnt;
	logic wr_icnt;
	logic [31:0] rdata;
	logic [31:0] stat_word;

	assign lane0 = pstrb[0];
	assign sel_fwd = (paddr == IDF_ADDR_FWD);
	assign sel_bcs = (paddr == IDF_ADDR_BCS);
	assign sel_hole = (paddr == IDF_ADDR_HOLE);
	assign sel_stat = (paddr == IDF_ADDR_STAT);
	assign sel_fcnt = (paddr == IDF_ADDR_FCNT);
	assign sel_icnt = (paddr == IDF_ADDR_ICNT);
	assign mapped = sel_fwd || sel_bcs || sel_hole || sel_stat || sel_fcnt || sel_icnt;

	assign wr_fwd = wr_en && sel_fwd && lane0;
	assign wr_bcs = wr_en && sel_bcs && lane0;
	assign wr_hole = wr_en && sel_hole && lane0;
	assign wr_fcnt = wr_en && sel_fcnt;
	assign wr_icnt = wr_en && sel_icnt;

	assign stat_word = {
		20'h00000,
		last_mbyte,
		seen,
		last_write,
		last_to_pci,
		2'b00,
		last_region
	};

	logic [31:0] fwd_word;
	logic [31:0] bcs_word;
	logic [31:0] hole_word;
	logic [31:0] fcnt_word;
	logic [31:0] icnt_word;

	assign fwd_word = {24'h000000, isa_dma_forwarding_control};
	assign bcs_word = {24'h000000, bios_chip_select_control};
	assign hole_word = {24'h000000, memory_hole_control};
	assign fcnt_word = {16'h0000, pci_count};
	assign icnt_word = {16'h0000, isa_count};

	// Unmapped addresses read as zero
	assign rdata = sel_fwd ? fwd_word :
		sel_bcs ? bcs_word :
		sel_hole ? hole_word :
		sel_stat ? stat_word :
		sel_fcnt ? fcnt_word :
		sel_icnt ? icnt_word :
		32'h00000000;

	idf_apb_slave u_apb (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.mapped(mapped),
		.rdata(rdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.wr_en(wr_en)
	);

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			isa_dma_forwarding_control <= IDF_FWD_RESET;
		end else if (wr_fwd) begin
			isa_dma_forwarding_control <= pwdata[7:0] & IDF_FWD_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bios_chip_select_control <= IDF_BCS_RESET;
		end else if (wr_bcs) begin
			bios_chip_select_control <= pwdata[7:0] & IDF_BCS_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			memory_hole_control <= IDF_HOLE_RESET;
		end else if (wr_hole) begin
			memory_hole_control <= pwdata[7:0] & IDF_HOLE_MASK;
		end
	end

	// ----------------------------------------------------------------
	// Field views
	// ----------------------------------------------------------------
	logic [3:0] ceiling;
	logic fwd_bios;
	logic fwd_vga;
	logic fwd_base;
	logic bios_decode;
	logic bios_wp;
	logic hole_en;
	logic [3:0] hole_mbyte;

	assign ceiling = isa_dma_forwarding_control[IDF_CEIL_HI:IDF_CEIL_LO];
	assign fwd_bios = isa_dma_forwarding_control[IDF_FWD_BIOS_BIT];
	assign fwd_vga = isa_dma_forwarding_control[IDF_FWD_VGA_BIT];
	assign fwd_base = isa_dma_forwarding_control[IDF_FWD_BASE_BIT];
	assign bios_decode = bios_chip_select_control[IDF_BCS_EN_BIT];
	assign bios_wp = bios_chip_select_control[IDF_BCS_WP_BIT];
	assign hole_en = memory_hole_control[IDF_HOLE_EN_BIT];
	assign hole_mbyte = memory_hole_control[IDF_HOLE_HI:IDF_HOLE_LO];

	// ----------------------------------------------------------------
	// Region match
	// ----------------------------------------------------------------
	logic in_base;
	logic in_vga;
	logic in_bios;

	idf_range_match #(
		.AW(IDF_CAW),
		.LO(IDF_BASE_LO),
		.HI(IDF_BASE_HI)
	) u_base (
		.addr(cyc_addr),
		.hit(in_base)
	);

	idf_range_match #(
		.AW(IDF_CAW),
		.LO(IDF_VGA_LO),
		.HI(IDF_VGA_HI)
	) u_vga (
		.addr(cyc_addr),
		.hit(in_vga)
	);

	idf_range_match #(
		.AW(IDF_CAW),
		.LO(IDF_BIOS_LO),
		.HI(IDF_BIOS_HI)
	) u_bios (
		.addr(cyc_addr),
		.hit(in_bios)
	);

	// ----------------------------------------------------------------
	// Ceiling and hole
	// ----------------------------------------------------------------
	logic [3:0] cyc_mbyte;
	logic below_top;
	logic in_hole;
	logic main_to_pci;

	assign cyc_mbyte = cyc_addr[IDF_CAW-1:IDF_CAW-4];
	// Top is ceiling+1 Mbytes, so any Mbyte index up to ceiling is below it
	assign below_top = (cyc_mbyte <= ceiling);
	assign in_hole = hole_en && (cyc_mbyte == hole_mbyte);
	assign main_to_pci = below_top && !in_hole;

	// ----------------------------------------------------------------
	// Routing decision
	// ----------------------------------------------------------------
	logic bios_to_pci;
	logic next_to_pci;
	logic next_cs;
	idf_region_t next_region;

	// BIOS decode enable keeps the block on ISA whatever bit 3 says
	assign bios_to_pci = fwd_bios && !bios_decode;
	// Chip select only while BIOS decode is on; writes need the write protect bit (bit 2) set
	assign next_cs = in_bios && bios_decode && (!cyc_write || bios_wp);

	assign next_to_pci = in_bios ? bios_to_pci :
		in_vga ? fwd_vga :
		in_base ? fwd_base :
		main_to_pci;

	assign next_region = in_bios ? IDF_RG_BIOS :
		in_vga ? IDF_RG_VGA :
		in_base ? IDF_RG_BASE :
		in_hole ? IDF_RG_HOLE :
		IDF_RG_MAIN;

	// ----------------------------------------------------------------
	// Route outputs
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route_valid <= 1'b0;
			route_to_pci <= 1'b0;
			route_region <= 3'h0;
			bios_chip_select_n <= 1'b1;
		end else begin
			route_valid <= cyc_valid;
			route_to_pci <= cyc_valid && next_to_pci;
			route_region <= cyc_valid ? next_region : 3'h0;
			bios_chip_select_n <= !(cyc_valid && next_cs);
		end
	end

	// ----------------------------------------------------------------
	// Last decision status
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_to_pci <= 1'b0;
			last_write <= 1'b0;
			last_region <= IDF_RG_MAIN;
			last_mbyte <= 4'h0;
			seen <= 1'b0;
		end else if (cyc_valid) begin
			last_to_pci <= next_to_pci;
			last_write <= cyc_write;
			last_region <= next_region;
			last_mbyte <= cyc_mbyte;
			seen <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Route counters, each cleared by any write to its own address
	// ----------------------------------------------------------------
	logic count_pci;
	logic count_isa;
	logic [IDF_CNTW-1:0] next_pci_count;
	logic [IDF_CNTW-1:0] next_isa_count;

	assign count_pci = cyc_valid && next_to_pci;
	assign count_isa = cyc_valid && !next_to_pci;
	// A counted cycle in the clearing cycle is kept as the first count
	assign next_pci_count = wr_fcnt ? {{(IDF_CNTW-1){1'b0}}, count_pci} :
		count_pci ? pci_count + 1'b1 : pci_count;
	assign next_isa_count = wr_icnt ? {{(IDF_CNTW-1){1'b0}}, count_isa} :
		count_isa ? isa_count + 1'b1 : isa_count;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pci_count <= '0;
			isa_count <= '0;
		end else begin
			pci_count <= next_pci_count;
			isa_count <= next_isa_count;
		end
	end
endmodule : idf_forward
`default_nettype wire

// File: shared/idf_pkg.sv
// Constants and types of the ISA/DMA memory forwarding decode
package idf_pkg;
	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int IDF_PAW = 12;
	localparam int IDF_CAW = 24;
	localparam int IDF_CNTW = 16;

	// ----------------------------------------------------------------
	// Register indices and byte addresses
	// ----------------------------------------------------------------
	localparam logic [9:0] IDF_IDX_FWD = 10'h069;
	localparam logic [9:0] IDF_IDX_BCS = 10'h06c;
	localparam logic [9:0] IDF_IDX_HOLE = 10'h06d;
	localparam logic [9:0] IDF_IDX_STAT = 10'h06e;
	localparam logic [9:0] IDF_IDX_FCNT = 10'h06f;
	localparam logic [9:0] IDF_IDX_ICNT = 10'h070;
	localparam logic [11:0] IDF_ADDR_FWD = {IDF_IDX_FWD, 2'b00};
	localparam logic [11:0] IDF_ADDR_BCS = {IDF_IDX_BCS, 2'b00};
	localparam logic [11:0] IDF_ADDR_HOLE = {IDF_IDX_HOLE, 2'b00};
	localparam logic [11:0] IDF_ADDR_STAT = {IDF_IDX_STAT, 2'b00};
	localparam logic [11:0] IDF_ADDR_FCNT = {IDF_IDX_FCNT, 2'b00};
	localparam logic [11:0] IDF_ADDR_ICNT = {IDF_IDX_ICNT, 2'b00};

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int IDF_CEIL_HI = 7;
	localparam int IDF_CEIL_LO = 4;
	localparam int IDF_FWD_BIOS_BIT = 3;
	localparam int IDF_FWD_VGA_BIT = 2;
	localparam int IDF_FWD_BASE_BIT = 1;
	localparam logic [7:0] IDF_FWD_RESET = 8'h02;
	localparam logic [7:0] IDF_FWD_MASK = 8'hfe;
	localparam int IDF_BCS_EN_BIT = 6;
	localparam int IDF_BCS_WP_BIT = 2;
	localparam logic [7:0] IDF_BCS_RESET = 8'h00;
	localparam logic [7:0] IDF_BCS_MASK = 8'h44;
	localparam int IDF_HOLE_EN_BIT = 0;
	localparam int IDF_HOLE_HI = 7;
	localparam int IDF_HOLE_LO = 4;
	localparam logic [7:0] IDF_HOLE_RESET = 8'h00;
	localparam logic [7:0] IDF_HOLE_MASK = 8'hf1;

	// ----------------------------------------------------------------
	// Decoded address ranges
	// ----------------------------------------------------------------
	localparam logic [23:0] IDF_BASE_LO = 24'h080000;
	localparam logic [23:0] IDF_BASE_HI = 24'h09ffff;
	localparam logic [23:0] IDF_VGA_LO = 24'h0a0000;
	localparam logic [23:0] IDF_VGA_HI = 24'h0bffff;
	localparam logic [23:0] IDF_BIOS_LO = 24'h0e0000;
	localparam logic [23:0] IDF_BIOS_HI = 24'h0effff;

	typedef enum logic [2:0] {
		IDF_RG_MAIN,
		IDF_RG_HOLE,
		IDF_RG_BASE,
		IDF_RG_VGA,
		IDF_RG_BIOS
	} idf_region_t;
endpackage : idf_pkg

// File: verilog/idf_range_match.sv
// Inclusive address range comparator
`timescale 1ns/1ps
`default_nettype none
module idf_range_match #(
	parameter int AW = 24,
	parameter logic [AW-1:0] LO = '0,
	parameter logic [AW-1:0] HI = '1
) (
	input wire logic [AW-1:0] addr,
	output logic hit
);
	assign hit = (addr >= LO) && (addr <= HI);
endmodule : idf_range_match
`default_nettype wire

// File: verilog/idf_apb_slave.sv
// APB slave handshake with one access cycle
`timescale 1ns/1ps
`default_nettype none
module idf_apb_slave (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic mapped,
	input wire logic [31:0] rdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic wr_en
);
	logic setup;

	// ----------------------------------------------------------------
	// Answer is prepared in the setup cycle
	// ----------------------------------------------------------------
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready && pwrite && !pslverr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup) begin
				prdata <= (mapped && !pwrite) ? rdata : 32'h00000000;
			end
		end
	end
endmodule : idf_apb_slave
`default_nettype wire

// File: verif/idf_forward_properties.sv
// Assertion checker for the forwarding decode, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module idf_forward_properties
	import idf_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cyc_valid,
	input wire logic [IDF_CAW-1:0] cyc_addr,
	input wire logic route_valid,
	input wire logic route_to_pci,
	input wire logic [2:0] route_region,
	input wire logic bios_chip_select_n
);
	// ----------------------------------------------------------------
	// Range hits
	// ----------------------------------------------------------------
	wire in_base = cyc_addr >= IDF_BASE_LO && cyc_addr <= IDF_BASE_HI;
	wire in_vga = cyc_addr >= IDF_VGA_LO && cyc_addr <= IDF_VGA_HI;
	wire in_bios = cyc_addr >= IDF_BIOS_LO && cyc_addr <= IDF_BIOS_HI;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_take; cyc_valid |=> route_valid; endproperty
	a_take: assert property (p_take) else $error("no route answer");
	property p_rv; route_valid |-> $past(cyc_valid); endproperty
	a_rv: assert property (p_rv) else $error("route answer without cycle");
	property p_idle;
		!route_valid |-> !route_to_pci && route_region == 3'h0 && bios_chip_select_n;
	endproperty
	a_idle: assert property (p_idle) else $error("route outputs not idle");
	property p_base; cyc_valid && in_base |=> route_region == IDF_RG_BASE; endproperty
	a_base: assert property (p_base) else $error("wrong region for 80000");
	property p_vga; cyc_valid && in_vga |=> route_region == IDF_RG_VGA; endproperty
	a_vga: assert property (p_vga) else $error("wrong region for A0000");
	property p_bios; cyc_valid && in_bios |=> route_region == IDF_RG_BIOS; endproperty
	a_bios: assert property (p_bios) else $error("wrong region for E0000");
	property p_cs_isa; !bios_chip_select_n |-> route_valid && !route_to_pci; endproperty
	a_cs_isa: assert property (p_cs_isa) else $error("chip select with PCI route");
	property p_cs_rng; cyc_valid && !in_bios |=> bios_chip_select_n; endproperty
	a_cs_rng: assert property (p_cs_rng) else $error("chip select outside BIOS");
	property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
	a_rdy: assert property (p_rdy) else $error("bus answer not one cycle");
endmodule : idf_forward_properties
bind idf_forward idf_forward_properties u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .cyc_valid(cyc_valid),
	.cyc_addr(cyc_addr), .route_valid(route_valid), .route_to_pci(route_to_pci),
	.route_region(route_region), .bios_chip_select_n(bios_chip_select_n));
`default_nettype wire

// File: verif/idf_isa_master.sv
// Model of the ISA master and DMA side that starts memory cycles
`timescale 1ns/1ps
`default_nettype none
module idf_isa_master
	import idf_pkg::*;
(
	input wire logic pclk,
	output logic cyc_valid,
	output logic [IDF_CAW-1:0] cyc_addr,
	output logic cyc_write
);
	initial begin
		cyc_valid = 1'b0;
		cyc_addr = 24'h000000;
		cyc_write = 1'b0;
	end
	// One cycle; afterwards address and direction stop showing the old value
	task automatic issue(input logic [IDF_CAW-1:0] a, input logic w);
		@(posedge pclk);
		cyc_valid <= 1'b1;
		cyc_addr <= a;
		cyc_write <= w;
		@(posedge pclk);
		cyc_valid <= 1'b0;
		cyc_addr <= ~a;
		cyc_write <= ~w;
	endtask : issue
endmodule : idf_isa_master
`default_nettype wire

// File: verif/tb.sv
// Self-checking testbench of the forwarding decode
`timescale 1ns/1ps
`default_nettype none
module tb
	import idf_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [IDF_PAW-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [3:0] wstrb;
	logic cyc_valid, cyc_write, route_valid, route_to_pci, bios_chip_select_n;
	logic [IDF_CAW-1:0] cyc_addr;
	logic [2:0] route_region;
	int failures, compares;
	idf_forward dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr),
		.cyc_write(cyc_write), .route_valid(route_valid), .route_to_pci(route_to_pci),
		.route_region(route_region), .bios_chip_select_n(bios_chip_select_n));
	idf_isa_master m (.pclk(pclk), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr),
		.cyc_write(cyc_write));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= w ? wstrb : 4'h0;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic route(input logic [23:0] a, input logic w, input logic p,
		input logic [2:0] r, input logic c);
		m.issue(a, w);
		#1;
		chk({26'h0, route_valid, route_to_pci, route_region, bios_chip_select_n},
			{26'h0, 1'b1, p, r, c});
	endtask : route
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		apb(1'b0, IDF_ADDR_FWD, 32'h0);
		chk(rd, 32'h00000002);
		apb(1'b0, 12'h000, 32'h0);
		chk({31'h0, err}, 32'h00000001);
		apb(1'b1, IDF_ADDR_FWD, 32'h000000ff);
		apb(1'b0, IDF_ADDR_FWD, 32'h0);
		chk(rd, 32'h000000fe);
	endtask : t_regs
	task automatic t_regions();
		logic [7:0] v;
		for (int i = 0; i < 2; i++) begin
			v = i ? 8'h0e : 8'h00;
			apb(1'b1, IDF_ADDR_FWD, {24'h0, v});
			route(24'h09ffff, 1'b0, v[1], IDF_RG_BASE, 1'b1);
			route(24'h0a0000, 1'b1, v[2], IDF_RG_VGA, 1'b1);
			route(24'h0e0000, 1'b0, v[3], IDF_RG_BIOS, 1'b1);
		end
	endtask : t_regions
	task automatic t_bios();
		apb(1'b1, IDF_ADDR_BCS, 32'h00000040);
		route(24'h0effff, 1'b0, 1'b0, IDF_RG_BIOS, 1'b0);
		route(24'h0e8000, 1'b1, 1'b0, IDF_RG_BIOS, 1'b1);
		apb(1'b1, IDF_ADDR_BCS, 32'h00000044);
		route(24'h0e0000, 1'b1, 1'b0, IDF_RG_BIOS, 1'b0);
		apb(1'b1, IDF_ADDR_BCS, 32'h0);
		route(24'h0e0000, 1'b0, 1'b1, IDF_RG_BIOS, 1'b1);
	endtask : t_bios
	task automatic t_ceiling();
		logic [3:0] n;
		for (int i = 0; i < 16; i++) begin
			n = i[3:0];
			apb(1'b1, IDF_ADDR_FWD, {24'h0, n, 4'h0});
			route({n, 20'hfffff}, 1'b0, 1'b1, IDF_RG_MAIN, 1'b1);
			if (i < 15) begin
				route({n + 4'h1, 20'h0}, 1'b1, 1'b0, IDF_RG_MAIN, 1'b1);
			end
		end
	endtask : t_ceiling
	task automatic t_hole();
		apb(1'b1, IDF_ADDR_FWD, 32'h000000f0);
		apb(1'b1, IDF_ADDR_HOLE, 32'h00000051);
		route(24'h500000, 1'b0, 1'b0, IDF_RG_HOLE, 1'b1);
		route(24'h5fffff, 1'b1, 1'b0, IDF_RG_HOLE, 1'b1);
		route(24'h4fffff, 1'b0, 1'b1, IDF_RG_MAIN, 1'b1);
	endtask : t_hole
	task automatic t_count();
		apb(1'b1, IDF_ADDR_FCNT, 32'h0);
		apb(1'b1, IDF_ADDR_ICNT, 32'h0);
		route(24'h500000, 1'b0, 1'b0, IDF_RG_HOLE, 1'b1);
		route(24'h200000, 1'b1, 1'b1, IDF_RG_MAIN, 1'b1);
		apb(1'b0, IDF_ADDR_FCNT, 32'h0);
		chk(rd, 32'h00000001);
		apb(1'b0, IDF_ADDR_ICNT, 32'h0);
		chk(rd, 32'h00000001);
		apb(1'b1, IDF_ADDR_STAT, 32'hffffffff);
		apb(1'b0, IDF_ADDR_STAT, 32'h0);
		chk(rd, 32'h000002e0);
		wstrb = 4'he;
		apb(1'b1, IDF_ADDR_FWD, 32'h00000000);
		wstrb = 4'hf;
		apb(1'b0, IDF_ADDR_FWD, 32'h0);
		chk(rd, 32'h000000f0);
	endtask : t_count
	task automatic end_of_test();
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test
	// ----------------------------------------------------------------
	// Clock, reset, sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
		wstrb = 4'hf;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_regions();
		t_bios();
		t_ceiling();
		t_hole();
		t_count();
		end_of_test();
	end
	initial begin
		repeat (5000) @(posedge pclk);
		failures++;
		end_of_test();
	end
endmodule : tb
`default_nettype wire
